// file: hw/mn_params.svh
// constants of the monitor sequencer: offsets, fields, reset values, timing
`ifndef MN_PARAMS_SVH
`define MN_PARAMS_SVH

// ***************************************************************
// channel layout
// ***************************************************************
`define MN_NCH 8
`define MN_CH_W 3
`define MN_CH_LOCAL 3'h6
`define MN_CH_REMOTE 3'h7
`define MN_AVG_N 16
`define MN_SUB_LAST 4'hf
`define MN_ACC_W 12

// ***************************************************************
// register offsets (8-bit register index space)
// ***************************************************************
`define MN_VAL_BASE 8'h20
`define MN_HI_BASE 8'h30
`define MN_LO_BASE 8'h38
`define MN_CFG_OFS 8'h40
`define MN_ST1_OFS 8'h41
`define MN_ST2_OFS 8'h42

// ***************************************************************
// field positions and reset values
// ***************************************************************
`define MN_CFG_START_BIT 0
`define MN_ST2_REMOTE_BIT 0
`define MN_ST2_FAULT_BIT 6
`define MN_RST_VAL 8'h00

// ***************************************************************
// timing
// ***************************************************************
`define MN_CLK_NS 20.0
`define MN_SLOT_MS 11.6
`define MN_REMOTE_MS 34.8

`endif

// file: hw/mn_pkg.sv
// types shared by the monitor sequencer files
package mn_pkg;

   // sequencer states
   typedef enum logic [1:0] {
      MN_IDLE  = 2'b00,
      MN_WAIT  = 2'b01,
      MN_CONV  = 2'b10,
      MN_STORE = 2'b11
   } mn_state_t;

   // one register write from the serial bus engine
   typedef struct packed {
      logic en;
      logic [7:0] addr;
      logic [7:0] data;
   } mn_wr_t;

   // one converter answer
   typedef struct packed {
      logic done;
      logic [7:0] data;
   } mn_adc_t;

endpackage

// file: hw/mn_limit_cmp.sv
// window comparator of one result against its high and low limits
`timescale 1ns/1ps
`default_nettype none

module mn_limit_cmp
   import mn_pkg::*;
(
   input wire logic [7:0] value,
   input wire logic [7:0] hi_lim,
   input wire logic [7:0] lo_lim,
   input wire logic is_signed,
   output logic out_of_lim
);

   // strict compare, signed for temperature channels
   always_comb begin
      if (is_signed) begin
         out_of_lim = ($signed(value) > $signed(hi_lim)) || ($signed(value) < $signed(lo_lim));
      end else begin
         out_of_lim = (value > hi_lim) || (value < lo_lim);
      end
   end

endmodule

`default_nettype wire

// file: hw/mn_monitor_seq.sv
// round-robin monitor sequencer with value, limit and status registers
// Function
// - start bit 0 begins monitoring loop
// - channels converted in turn, results stored
// - loop repeats until start bit cleared
// - each measurement stored and compared with limits
// - status bit mirrors last comparison only
// - status reads never alter status bits
// - status 2 bit 6 flags remote fault
// - fault covers shorts and opens on diode
// - temperatures are 8-bit two's complement
// - remote result averages sixteen sub-measurements
// - excitation toggles between base and multiple
// - stored values readable while loop runs
// - out-of-limit results drive interrupt sources
// - one normal input converted per 11.6 ms
// - start cleared means idle, registers reachable
// - values and limits reset to zero
`include "mn_params.svh"
`timescale 1ns/1ps
`default_nettype none

module mn_monitor_seq
   import mn_pkg::*;
#(
   parameter int SLOT_CYC = int'(`MN_SLOT_MS * 1.0e6 / `MN_CLK_NS),
   parameter int SUB_CYC = int'(`MN_REMOTE_MS * 1.0e6 / `MN_CLK_NS / `MN_AVG_N)
) (
   input wire logic clk,
   input wire logic rst,
   input wire mn_wr_t host_wr,
   input wire logic host_rd,
   input wire logic [7:0] host_rd_addr,
   output logic [7:0] host_rd_data_r,
   input wire mn_adc_t adc_res,
   input wire logic [3:0] diode_fault_pins,
   output logic adc_start_r,
   output logic [`MN_CH_W-1:0] adc_chan_r,
   output logic exc_high_r,
   output logic low_power_r,
   output logic irq_volt_r,
   output logic irq_temp_r
);

   // ***************************************************************
   // declarations
   // ***************************************************************
   localparam int NCH = `MN_NCH;
   localparam logic [20:0] SLOT_END = 21'(SLOT_CYC - 1);
   localparam logic [20:0] SUB_END = 21'(SUB_CYC - 1);
   localparam logic [20:0] SUB_HALF = 21'(SUB_CYC / 2);

   mn_state_t state_r;                     // sequencer state
   logic [`MN_CH_W-1:0] ch_r;              // channel being measured
   logic [20:0] cnt_r;                     // slot timer
   logic [3:0] sub_r;                      // remote sub-measurement index
   logic signed [`MN_ACC_W-1:0] acc_r;     // remote sum
   logic [7:0] sample_r;                   // last plain result
   logic [7:0] cfg_r;                      // configuration register
   logic [7:0] value_r [NCH];              // value registers
   logic [7:0] hi_r [NCH];                 // high limits
   logic [7:0] lo_r [NCH];                 // low limits
   logic [NCH-1:0] stat_r;                 // per-channel out-of-limit bits
   logic fault_r;                          // remote diode fault status
   logic fault_seen_r;                     // fault seen during this remote run
   logic [3:0] flt_s1_r;                   // fault synchroniser stage 1
   logic [3:0] flt_s2_r;                   // fault synchroniser stage 2
   logic [7:0] rd_mux;                     // read data before the flop
   logic [7:0] store_val;                  // result to be stored
   logic oor;                              // comparator answer
   logic start;
   logic remote;
   logic store;
   logic [20:0] slot_end;
   assign start = cfg_r[`MN_CFG_START_BIT];
   assign remote = (ch_r == `MN_CH_REMOTE);
   assign store = (state_r == MN_STORE);
   assign slot_end = remote ? SUB_END : SLOT_END;
   // average of sixteen is the sum shifted by four, sign kept
   assign store_val = remote ? acc_r[`MN_ACC_W-1:4] : sample_r;
   // temperature channels compare as signed
   mn_limit_cmp u_cmp (.value(store_val), .hi_lim(hi_r[ch_r]), .lo_lim(lo_r[ch_r]),
      .is_signed(ch_r >= `MN_CH_LOCAL), .out_of_lim(oor));

   // ***************************************************************
   // sequencer
   // ***************************************************************
   // walks the channels, times slots, gathers remote sub-results
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= MN_IDLE;
         ch_r <= '0;
         cnt_r <= '0;
         sub_r <= '0;
         acc_r <= '0;
         sample_r <= `MN_RST_VAL;
         adc_start_r <= 1'b0;
         adc_chan_r <= '0;
      end else begin
         adc_start_r <= 1'b0;
         unique case (state_r)
            // converter idle until started
            MN_IDLE: begin
               cnt_r <= '0;
               sub_r <= '0; // an aborted remote sum is dropped here
               acc_r <= '0;
               if (start) begin
                  state_r <= MN_WAIT;
               end
            end
            // one slot per plain input, sixteen per remote
            MN_WAIT: begin
               if (!start) begin
                  state_r <= MN_IDLE;
               end else if (cnt_r == slot_end) begin
                  cnt_r <= '0;
                  adc_start_r <= 1'b1;
                  adc_chan_r <= ch_r;
                  state_r <= MN_CONV;
               end else begin
                  cnt_r <= cnt_r + 21'h1;
               end
            end
            // wait for the converter answer
            MN_CONV: begin
               if (!start) begin
                  state_r <= MN_IDLE;
               end else if (adc_res.done) begin
                  if (remote) begin
                     acc_r <= acc_r + {{4{adc_res.data[7]}}, adc_res.data};
                     if (sub_r == `MN_SUB_LAST) begin
                        sub_r <= '0;
                        state_r <= MN_STORE;
                     end else begin
                        sub_r <= sub_r + 4'h1;
                        state_r <= MN_WAIT;
                     end
                  end else begin
                     sample_r <= adc_res.data;
                     state_r <= MN_STORE;
                  end
               end
            end
            // result stored this cycle, move to next channel
            MN_STORE: begin
               acc_r <= '0;
               ch_r <= (ch_r == `MN_CH_W'(NCH - 1)) ? '0 : ch_r + `MN_CH_W'(1);
               state_r <= start ? MN_WAIT : MN_IDLE;
            end
         endcase
      end
   end
   // base current first half of a remote slot, multiple after
   always_ff @(posedge clk) begin
      if (rst) begin
         exc_high_r <= 1'b0;
      end else begin
         exc_high_r <= remote && (((state_r == MN_WAIT) && (cnt_r >= SUB_HALF))
                                  || (state_r == MN_CONV));
      end
   end

   // ***************************************************************
   // host registers
   // ***************************************************************
   // writable in any state, also while idle
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_r <= `MN_RST_VAL;
      end else if (host_wr.en && (host_wr.addr == `MN_CFG_OFS)) begin
         cfg_r <= host_wr.data;
      end
   end
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      // limits written by the host, all zero after reset
      always_ff @(posedge clk) begin
         if (rst) begin
            hi_r[i] <= `MN_RST_VAL;
            lo_r[i] <= `MN_RST_VAL;
         end else if (host_wr.en) begin
            if (host_wr.addr == (`MN_HI_BASE + 8'(i))) begin
               hi_r[i] <= host_wr.data;
            end
            if (host_wr.addr == (`MN_LO_BASE + 8'(i))) begin
               lo_r[i] <= host_wr.data;
            end
         end
      end
      // value and status follow the last store of this channel
      always_ff @(posedge clk) begin
         if (rst) begin
            value_r[i] <= `MN_RST_VAL;
            stat_r[i] <= 1'b0;
         end else if (store && (ch_r == `MN_CH_W'(i))) begin
            value_r[i] <= store_val;
            stat_r[i] <= oor;
         end
      end
   end
   // two-flop synchroniser on the analog fault detectors
   always_ff @(posedge clk) begin
      if (rst) begin
         flt_s1_r <= '0;
         flt_s2_r <= '0;
      end else begin
         flt_s1_r <= diode_fault_pins;
         flt_s2_r <= flt_s1_r;
      end
   end
   // any short or open during a remote run sets the fault bit
   always_ff @(posedge clk) begin
      if (rst) begin
         fault_seen_r <= 1'b0;
         fault_r <= 1'b0;
      end else if (store && remote) begin
         fault_r <= fault_seen_r || (|flt_s2_r);
         fault_seen_r <= 1'b0;
      end else if (remote && (state_r != MN_IDLE) && (|flt_s2_r)) begin
         fault_seen_r <= 1'b1;
      end
   end

   // ***************************************************************
   // host reads, power state and interrupt sources
   // ***************************************************************
   // read mux, no side effects on any register
   always_comb begin
      rd_mux = 8'h00;
      if (host_rd_addr[7:3] == `MN_VAL_BASE >> 3) begin
         rd_mux = value_r[host_rd_addr[2:0]];
      end else if (host_rd_addr[7:3] == `MN_HI_BASE >> 3) begin
         rd_mux = hi_r[host_rd_addr[2:0]];
      end else if (host_rd_addr[7:3] == `MN_LO_BASE >> 3) begin
         rd_mux = lo_r[host_rd_addr[2:0]];
      end else if (host_rd_addr == `MN_CFG_OFS) begin
         rd_mux = cfg_r;
      end else if (host_rd_addr == `MN_ST1_OFS) begin
         rd_mux = {1'b0, stat_r[6:0]};
      end else if (host_rd_addr == `MN_ST2_OFS) begin
         rd_mux = {1'b0, fault_r, 5'h00, stat_r[`MN_ST2_REMOTE_BIT + 7]};
      end
   end
   // read data held until the next read
   always_ff @(posedge clk) begin
      if (rst) begin
         host_rd_data_r <= 8'h00;
      end else if (host_rd) begin
         host_rd_data_r <= rd_mux;
      end
   end
   // voltage and temperature out-of-limit levels
   always_ff @(posedge clk) begin
      if (rst) begin
         low_power_r <= 1'b1;
         irq_volt_r <= 1'b0;
         irq_temp_r <= 1'b0;
      end else begin
         low_power_r <= !start;
         irq_volt_r <= |stat_r[5:0];
         irq_temp_r <= |stat_r[7:6];
      end
   end

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   start_run_a: assert property ((state_r == MN_IDLE) && start |=> state_r == MN_WAIT)
      else $error("start bit did not begin the loop");
   stop_idle_a: assert property (!start && (state_r != MN_STORE) |=> state_r == MN_IDLE)
      else $error("loop kept running with start bit clear");
   adc_chan_a: assert property (adc_start_r |-> adc_chan_r == $past(ch_r) && state_r == MN_CONV)
      else $error("conversion started on wrong channel");
   value_store_a: assert property (store && !remote |=> value_r[$past(ch_r)] == $past(sample_r))
      else $error("plain result not stored");
   status_last_a: assert property (store |=> stat_r[$past(ch_r)] == $past(oor))
      else $error("status bit not equal to last comparison");
   read_keep_a: assert property (host_rd && !store |=> stat_r == $past(stat_r))
      else $error("status changed by a read");
   fault_bit_a: assert property (store && remote |=> fault_r == $past(fault_seen_r || (|flt_s2_r)))
      else $error("remote fault bit wrong");
   avg_store_a: assert property (store && remote |=> value_r[`MN_CH_REMOTE] == $past(acc_r[11:4]))
      else $error("remote average not stored");
   exc_phase_a: assert property (remote && (state_r == MN_WAIT) && (cnt_r < SUB_HALF) |=> !exc_high_r)
      else $error("excitation high in base phase");
   irq_src_a: assert property (##1 irq_volt_r == $past(|stat_r[5:0]))
      else $error("voltage interrupt source wrong");
   low_pwr_a: assert property (##1 low_power_r == $past(!start))
      else $error("low power flag wrong");
   round_done_c: cover property (store && remote);
   fault_set_c: cover property (!fault_r ##1 fault_r);
   stop_conv_c: cover property ((state_r == MN_CONV) && !start);
endmodule

`default_nettype wire

// file: bench/mn_adc_model.sv
// converter stand-in: answers each conversion start after a set latency
`timescale 1ns/1ps
`default_nettype none

module mn_adc_model
   import mn_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [2:0] chan,
   input wire logic [63:0] tab,
   input wire logic [3:0] lat,
   output mn_adc_t res
);
   logic busy_r; // a conversion is in flight
   logic flip_r; // remote noise toggle, one step per remote answer
   logic [3:0] cnt_r; // cycles left before the answer
   logic [2:0] ch_r; // channel taken with the start pulse

   // latency counter and answer; data never holds outside the done cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         busy_r <= 1'b0;
         flip_r <= 1'b0;
         cnt_r <= 4'h0;
         ch_r <= 3'h0;
         res <= '0;
      end else begin
         res.done <= 1'b0;
         res.data <= ~res.data;
         if (start) begin
            busy_r <= 1'b1;
            cnt_r <= lat;
            ch_r <= chan;
         end else if (busy_r) begin
            if (cnt_r == 4'h0) begin
               // remote answers alternate by one code so the average is not trivial
               busy_r <= 1'b0;
               res.done <= 1'b1;
               res.data <= tab[{ch_r, 3'h0} +: 8] + {7'h00, flip_r & (ch_r == 3'h7)};
               if (ch_r == 3'h7) begin
                  flip_r <= ~flip_r;
               end
            end else begin
               cnt_r <= cnt_r - 4'h1;
            end
         end
      end
   end
endmodule

`default_nettype wire

// file: bench/mn_monitor_seq_test.sv
// self-checking bench of the monitor sequencer
`timescale 1ns/1ps
`default_nettype none

module mn_monitor_seq_test
   import mn_pkg::*;
;
   localparam int SLOT = 8; // shortened slot and sub-slot counts
   logic clk = 1'b0;
   logic rst = 1'b1;
   mn_wr_t host_wr = '0;
   logic host_rd = 1'b0;
   logic [7:0] host_rd_addr = 8'h00;
   logic [7:0] host_rd_data_r;
   mn_adc_t adc_res;
   logic [3:0] diode_fault_pins = 4'h0;
   logic adc_start_r, exc_high_r, low_power_r, irq_volt_r, irq_temp_r;
   logic [2:0] adc_chan_r;
   logic [63:0] tab = {8'he1, 8'hfb, 8'h00, 8'h10, 8'h0f, 8'hc8, 8'hc9, 8'h80}; // ch7..ch0
   logic [3:0] lat = 4'h0; // converter latency, prompt at first
   int n_fail = 0, samples_checked = 0, n_start = 0, n_rem = 0, n_exc = 0;
   logic [2:0] prev_ch = 3'h0;
   logic prev_v = 1'b0;
   logic exc_d = 1'b0;

   always #10 clk = ~clk;

   mn_monitor_seq #(.SLOT_CYC(SLOT), .SUB_CYC(SLOT)) uut (.clk(clk), .rst(rst),
      .host_wr(host_wr), .host_rd(host_rd), .host_rd_addr(host_rd_addr),
      .host_rd_data_r(host_rd_data_r), .adc_res(adc_res), .diode_fault_pins(diode_fault_pins),
      .adc_start_r(adc_start_r), .adc_chan_r(adc_chan_r), .exc_high_r(exc_high_r),
      .low_power_r(low_power_r), .irq_volt_r(irq_volt_r), .irq_temp_r(irq_temp_r));
   mn_adc_model adc (.clk(clk), .rst(rst), .start(adc_start_r), .chan(adc_chan_r),
      .tab(tab), .lat(lat), .res(adc_res));

   // ***************************************************************
   // compare, bus and wait tasks
   // ***************************************************************
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error t=%0t byte got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error t=%0t flag got %b expected %b", $time, got, exp);
      end
   endtask
   // write: one-cycle enable, takes effect at the sampling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      host_wr <= '{en: 1'b1, addr: a, data: d};
      @(posedge clk);
      host_wr.en <= 1'b0;
      #1;
   endtask
   // read: data valid one cycle after the strobe edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      host_rd <= 1'b1;
      host_rd_addr <= a;
      @(posedge clk);
      host_rd <= 1'b0;
      #1;
      chk8(host_rd_data_r, exp);
   endtask
   task automatic wait_ch0;
      int k;
      for (k = 0; k < 4000; k++) begin
         @(posedge clk);
         #1;
         if (adc_start_r && adc_chan_r == 3'h0) break;
      end
      if (k == 4000) begin
         n_fail++;
         $display("Error t=%0t no conversion start seen", $time);
      end
   endtask
   // one full round from channel 0 back to channel 0
   task automatic run_loop;
      wait_ch0();
      n_rem = 0;
      n_exc = 0;
      wait_ch0();
      chk8(8'(n_rem), 8'h10);
      chk8(8'(n_exc), 8'h10);
   endtask
   task automatic print_verdict;
      $display("n_fail=%0d samples_checked=%0d", n_fail, samples_checked);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // watches channel order, remote starts and excitation steps
   always @(posedge clk) begin
      exc_d <= exc_high_r;
      if (exc_high_r && !exc_d) n_exc++;
      if (adc_start_r) n_start++;
      if (low_power_r) begin
         prev_v <= 1'b0;
      end else if (adc_start_r) begin
         if (adc_chan_r == 3'h7) n_rem++;
         if (prev_v) chk1(adc_chan_r == prev_ch + 3'h1 || (prev_ch == 3'h7 && adc_chan_r == 3'h7), 1'b1);
         prev_ch <= adc_chan_r;
         prev_v <= 1'b1;
      end
   end

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk1(low_power_r, 1'b1);
      for (int a = 32; a <= 66; a++) rd(8'(a), 8'h00);
      for (int c = 0; c < 6; c++) begin
         wr(8'h30 + 8'(c), 8'hc8);
         wr(8'h38 + 8'(c), 8'h10);
      end
      wr(8'h36, 8'h50);
      wr(8'h3e, 8'hf6);
      wr(8'h37, 8'h40);
      wr(8'h3f, 8'he0);
      wr(8'h40, 8'h01);
      @(posedge clk);
      #1;
      chk1(low_power_r, 1'b0);
      run_loop();
      rd(8'h41, 8'h2a);
      rd(8'h41, 8'h2a);
      rd(8'h42, 8'h00);
      rd(8'h21, 8'hc9);
      rd(8'h26, 8'hfb);
      rd(8'h27, 8'he1);
      chk1(irq_volt_r, 1'b1);
      chk1(irq_temp_r, 1'b0);
      // slow converter, widened channel 1, tightened remote low limit
      @(posedge clk);
      lat <= 4'h9;
      wr(8'h31, 8'hff);
      wr(8'h3f, 8'he2);
      run_loop();
      rd(8'h41, 8'h28);
      rd(8'h42, 8'h01);
      chk1(irq_temp_r, 1'b1);
      // each diode fault kind in turn, then healed
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         diode_fault_pins <= (i < 4) ? 4'h1 << i : 4'h0;
         run_loop();
         rd(8'h42, (i < 4) ? 8'h41 : 8'h01);
      end
      // stop: conversions halt, registers stay reachable
      wr(8'h40, 8'h00);
      repeat (3) @(posedge clk);
      #1;
      chk1(low_power_r, 1'b1);
      n_start = 0;
      repeat (300) @(posedge clk);
      chk8(8'(n_start), 8'h00);
      wr(8'h20, 8'h55);
      rd(8'h20, 8'h80);
      rd(8'h50, 8'h00);
      rd(8'h40, 8'h00);
      rd(8'h41, 8'h28);
      print_verdict();
   end

   // watchdog well beyond the expected run length
   initial begin
      #1000000;
      n_fail++;
      $display("Error t=%0t watchdog expired", $time);
      print_verdict();
   end
endmodule

`default_nettype wire
